// file: verilog/ufc_pkg.sv
/*
  Constants for the serial-port FIFO and interrupt control block.
  Assumes a 40 MHz clock and a 16x receive baud tick from the baud logic.
*/
`default_nettype none
package ufc_pkg;
  // Word byte addresses on the register bus
  localparam logic [4:0] ADR_DATA = 5'h00;
  localparam logic [4:0] ADR_IEN  = 5'h04;
  localparam logic [4:0] ADR_IID  = 5'h08;
  localparam logic [4:0] ADR_LST  = 5'h0c;
  localparam logic [4:0] ADR_CFG  = 5'h10;
  // fifo_control fields
  localparam int FC_EN = 0;
  localparam int FC_RFL = 1;
  localparam int FC_TFL = 2;
  localparam int FC_TRG = 6;
  // interrupt_enable fields
  localparam int IE_RDA = 0;
  localparam int IE_THR = 1;
  localparam int IE_RLS = 2;
  // Receive trigger levels
  localparam logic [4:0] TRIG_00 = 5'h01;
  localparam logic [4:0] TRIG_01 = 5'h04;
  localparam logic [4:0] TRIG_10 = 5'h08;
  localparam logic [4:0] TRIG_11 = 5'h0e;
  // interrupt_identification codes
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_RLS  = 4'h6;
  localparam logic [3:0] ID_RDA  = 4'h4;
  localparam logic [3:0] ID_TMO  = 4'hc;
  localparam logic [3:0] ID_THR  = 4'h2;
  // FIFO geometry
  localparam int DEPTH = 16;
  localparam int AW = 4;
  localparam logic [4:0] DEPTH_FIFO = 5'h10;
  localparam logic [4:0] DEPTH_HOLD = 5'h01;
  // Timing, in baud ticks (16 per bit)
  localparam int TICK_SHIFT = 4;
  localparam int TMO_SHIFT = 6;
  localparam logic [3:0] CFG_RESET = 4'ha;
  localparam logic [1:0] TRG_RESET = 2'h0;
endpackage : ufc_pkg
`default_nettype wire

// file: verilog/ufc_top.sv
/*
  FIFO enable/flush, receive trigger, time-out and transmit-empty
  interrupts with priority encoding, behind a classic Wishbone slave.
  Assumes receive and transmit shifters on the same clock, a 16x receive
  baud tick pulse, and characters offered as one-cycle strobes.
*/
`default_nettype none
module ufc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        baud_tick_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic [2:0]  rx_err_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        tx_ready_i,
  input  wire logic        tx_busy_i,
  output logic             irq_o
);
  localparam int AW = ufc_pkg::AW;

  // Bus and register strobes
  logic             req;
  logic             wr;
  logic             rd;
  logic             rd_rbr;
  logic             rd_lsr;
  logic             rd_iid;
  logic             wr_thr;
  logic             wr_ien;
  logic             wr_fcr;
  logic             wr_cfg;
  logic             fifo_en;
  logic [1:0]       trig_sel;
  logic [2:0]       ien;
  logic [3:0]       cfg_bits;
  logic             en_chg;
  logic             rx_flush;
  logic             tx_flush;
  logic [4:0]       depth;
  logic [4:0]       trig_lvl;

  // Receive side state
  logic [10:0]      rx_mem [ufc_pkg::DEPTH];
  logic [AW-1:0]    rx_wp;
  logic [AW-1:0]    rx_rp;
  logic [4:0]       rx_cnt;
  logic [4:0]       rx_errs;
  logic             rx_push;
  logic             rx_pop;
  logic             top_seen;
  logic [3:0]       lst_err;
  logic [9:0]       tmo_cnt;
  logic [9:0]       tmo_lim;
  logic             tmo_pend;

  // Transmit side state
  logic [7:0]       tx_mem [ufc_pkg::DEPTH];
  logic [AW-1:0]    tx_wp;
  logic [AW-1:0]    tx_rp;
  logic [4:0]       tx_cnt;
  logic             tx_push;
  logic             tx_take;
  logic             transmit_holding_empty_q;
  logic             seen_two;
  logic             first_imm;
  logic             thr_pend;
  logic             dly_run;
  logic [9:0]       dly_cnt;
  logic [9:0]       dly_lim;

  // Interrupt sources and read data
  logic             src_rls;
  logic             src_rda;
  logic             src_tmo;
  logic             src_thr;
  logic [3:0]       id_code;
  logic [7:0]       iid_val;
  logic [7:0]       lst_val;
  logic [7:0]       next_rdata;

  // Bus decode: a request is taken on the edge where ack rises
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = req && wb_we_i && wb_sel_i[0];
  assign rd     = req && !wb_we_i;
  assign rd_rbr = rd && (wb_adr_i == ufc_pkg::ADR_DATA);
  assign rd_lsr = rd && (wb_adr_i == ufc_pkg::ADR_LST);
  assign rd_iid = rd && (wb_adr_i == ufc_pkg::ADR_IID);
  assign wr_thr = wr && (wb_adr_i == ufc_pkg::ADR_DATA);
  assign wr_ien = wr && (wb_adr_i == ufc_pkg::ADR_IEN);
  assign wr_fcr = wr && (wb_adr_i == ufc_pkg::ADR_IID);
  assign wr_cfg = wr && (wb_adr_i == ufc_pkg::ADR_CFG);

  assign en_chg   = wr_fcr && (wb_dat_i[ufc_pkg::FC_EN] != fifo_en);
  assign rx_flush = en_chg
      || (wr_fcr && wb_dat_i[ufc_pkg::FC_EN] && wb_dat_i[ufc_pkg::FC_RFL]);
  assign tx_flush = en_chg
      || (wr_fcr && wb_dat_i[ufc_pkg::FC_EN] && wb_dat_i[ufc_pkg::FC_TFL]);
  assign depth = fifo_en ? ufc_pkg::DEPTH_FIFO : ufc_pkg::DEPTH_HOLD;

  // Trigger level decode
  always_comb begin
    unique case (trig_sel)
      2'h0: trig_lvl = ufc_pkg::TRIG_00;
      2'h1: trig_lvl = ufc_pkg::TRIG_01;
      2'h2: trig_lvl = ufc_pkg::TRIG_10;
      2'h3: trig_lvl = ufc_pkg::TRIG_11;
    endcase
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_en  <= 1'b0;
      trig_sel <= ufc_pkg::TRG_RESET;
      ien      <= 3'h0;
      cfg_bits <= ufc_pkg::CFG_RESET;
    end else begin
      if (wr_fcr) begin
        fifo_en <= wb_dat_i[ufc_pkg::FC_EN];
        if (wb_dat_i[ufc_pkg::FC_EN]) begin
          trig_sel <= wb_dat_i[ufc_pkg::FC_TRG +: 2];
        end
      end
      if (wr_ien) begin
        ien <= wb_dat_i[2:0];
      end
      if (wr_cfg) begin
        cfg_bits <= wb_dat_i[3:0];
      end
    end
  end

  // Receive FIFO, error bits stored beside each character
  assign rx_push = rx_valid_i && (rx_cnt < depth);
  assign rx_pop  = rd_rbr && (rx_cnt != 5'h00);

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_flush) begin
      rx_wp   <= '0;
      rx_rp   <= '0;
      rx_cnt  <= 5'h00;
      rx_errs <= 5'h00;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp] <= {rx_err_i, rx_data_i};
        rx_wp         <= rx_wp + 1'b1;
      end
      if (rx_pop) begin
        rx_rp <= rx_rp + 1'b1;
      end
      rx_cnt  <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
      rx_errs <= rx_errs + {4'h0, rx_push && (rx_err_i != 3'h0)}
                 - {4'h0, rx_pop && (rx_mem[rx_rp][10:8] != 3'h0)};
    end
  end

  // Line status error bits: set wins over the read that clears them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lst_err  <= 4'h0;
      top_seen <= 1'b0;
    end else begin
      lst_err <= (rd_lsr ? 4'h0 : lst_err)
        | {(rx_cnt != 5'h00) && !top_seen ? rx_mem[rx_rp][10:8] : 3'h0,
           rx_valid_i && (rx_cnt >= depth)};
      if (rx_pop || rx_flush) begin
        top_seen <= 1'b0;
      end else if (rx_cnt != 5'h00) begin
        top_seen <= 1'b1;
      end
    end
  end

  // Idle timer in baud ticks, limit four character times
  assign tmo_lim = {cfg_bits, 6'h00};

  always_ff @(posedge clk_i) begin
    if (rst_i || rx_flush) begin
      tmo_cnt  <= 10'h000;
      tmo_pend <= 1'b0;
    end else if (rx_pop) begin
      tmo_cnt  <= 10'h000;
      tmo_pend <= 1'b0;
    end else if (rx_push && !tmo_pend) begin
      tmo_cnt <= 10'h000;
    end else if (!fifo_en || !ien[ufc_pkg::IE_RDA]) begin
      tmo_cnt  <= 10'h000;
      tmo_pend <= 1'b0;
    end else if (rx_cnt != 5'h00 && !tmo_pend) begin
      if (tmo_cnt >= tmo_lim) begin
        tmo_pend <= 1'b1;
      end else if (baud_tick_i) begin
        tmo_cnt <= tmo_cnt + 10'h001;
      end
    end
  end

  // Transmit FIFO and output holding stage
  assign tx_push = wr_thr && (tx_cnt < depth);
  assign tx_take = (!tx_valid_o || tx_ready_i) && (tx_cnt != 5'h00);

  always_ff @(posedge clk_i) begin
    if (rst_i || tx_flush) begin
      tx_wp  <= '0;
      tx_rp  <= '0;
      tx_cnt <= 5'h00;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp] <= wb_dat_i[7:0];
        tx_wp         <= tx_wp + 1'b1;
      end
      if (tx_take) begin
        tx_rp <= tx_rp + 1'b1;
      end
      tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_take};
    end
  end

  // Shift-side holding stage survives a flush
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
    end else if (tx_take && !tx_flush) begin
      tx_valid_o <= 1'b1;
      tx_data_o  <= tx_mem[tx_rp];
    end else if (tx_ready_i) begin
      tx_valid_o <= 1'b0;
    end
  end

  // Transmit-empty event with optional delay
  assign dly_lim = {2'h0, cfg_bits - 4'h1, 4'h0};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      transmit_holding_empty_q    <= 1'b1;
      seen_two  <= 1'b0;
      first_imm <= 1'b1;
      thr_pend  <= 1'b0;
      dly_run   <= 1'b0;
      dly_cnt   <= 10'h000;
    end else begin
      transmit_holding_empty_q <= (tx_cnt == 5'h00);
      if (en_chg) begin
        first_imm <= 1'b1;
      end
      if (tx_cnt >= 5'h02) begin
        seen_two <= 1'b1;
      end
      if (tx_push) begin
        dly_run <= 1'b0;
      end else if (dly_run && baud_tick_i) begin
        dly_cnt <= dly_cnt + 10'h001;
      end
      if (tx_cnt == 5'h00 && !transmit_holding_empty_q) begin
        seen_two <= 1'b0;
        if (seen_two || first_imm || !fifo_en) begin
          thr_pend  <= 1'b1;
          first_imm <= 1'b0;
        end else begin
          dly_run <= 1'b1;
          dly_cnt <= 10'h000;
        end
      end else if (dly_run && dly_cnt >= dly_lim && !tx_push) begin
        thr_pend <= 1'b1;
        dly_run  <= 1'b0;
      end else if (wr_thr || (rd_iid && id_code == ufc_pkg::ID_THR)) begin
        thr_pend <= 1'b0;
      end else if (wr_ien && wb_dat_i[ufc_pkg::IE_THR]
                   && !ien[ufc_pkg::IE_THR] && tx_cnt == 5'h00) begin
        thr_pend  <= 1'b1;
        first_imm <= 1'b0;
      end
    end
  end

  // Sources gated by their enables
  assign src_rls = ien[ufc_pkg::IE_RLS] && (lst_err != 4'h0);
  assign src_rda = ien[ufc_pkg::IE_RDA] && (fifo_en ? (rx_cnt >= trig_lvl)
                                      : (rx_cnt != 5'h00));
  assign src_tmo = tmo_pend;
  assign src_thr = ien[ufc_pkg::IE_THR] && thr_pend;

  // Priority encoder
  always_comb begin
    if (src_rls) begin
      id_code = ufc_pkg::ID_RLS;
    end else if (src_rda) begin
      id_code = ufc_pkg::ID_RDA;
    end else if (src_tmo) begin
      id_code = ufc_pkg::ID_TMO;
    end else if (src_thr) begin
      id_code = ufc_pkg::ID_THR;
    end else begin
      id_code = ufc_pkg::ID_NONE;
    end
  end

  assign iid_val = {fifo_en, fifo_en, 2'h0, id_code};
  assign lst_val = {fifo_en && (rx_errs != 5'h00),
                    tx_cnt == 5'h00 && !tx_valid_o && !tx_busy_i,
                    tx_cnt == 5'h00,
                    lst_err,
                    rx_cnt != 5'h00};

  // Read data select
  always_comb begin
    unique case (wb_adr_i)
      ufc_pkg::ADR_DATA: next_rdata = rx_mem[rx_rp][7:0];
      ufc_pkg::ADR_IEN:  next_rdata = {5'h00, ien};
      ufc_pkg::ADR_IID:  next_rdata = iid_val;
      ufc_pkg::ADR_LST:  next_rdata = lst_val;
      ufc_pkg::ADR_CFG:  next_rdata = {4'h0, cfg_bits};
      default:           next_rdata = 8'h00;
    endcase
  end

  // Bus answer: one-cycle ack, registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= {24'h000000, next_rdata};
      end
    end
  end

  // Interrupt request, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= src_rls || src_rda || src_tmo || src_thr;
    end
  end
endmodule : ufc_top
`default_nettype wire

// file: test/ufc_top_properties.sv
/*
  Port properties of the FIFO and interrupt control block.
  Assumes it is bound onto ufc_top and sees only its ports.
*/
`default_nettype none
module ufc_top_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [4:0]  wb_adr_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        tx_valid_o,
  input wire logic [7:0]  tx_data_o,
  input wire logic        tx_ready_i
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic rd_id;
  logic rd_ls;
  assign rd_id = wb_ack_o && !wb_we_i && wb_adr_i == ufc_pkg::ADR_IID;
  assign rd_ls = wb_ack_o && !wb_we_i && wb_adr_i == ufc_pkg::ADR_LST;
  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o
  ) else $error("request not acknowledged");
  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o
  ) else $error("ack longer than one cycle");
  AST_IEN_BITS: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == ufc_pkg::ADR_IEN
      |-> wb_dat_o[31:3] == '0
  ) else $error("unused enable bits set");
  AST_ID_NONE: assert property (
    rd_id && wb_dat_o[0] |-> wb_dat_o[3:1] == 3'h0
  ) else $error("source code without pending flag");
  AST_ID_TMO: assert property (
    rd_id && wb_dat_o[3] |-> wb_dat_o[2:0] == 3'h4
  ) else $error("time-out flag with wrong code");
  AST_ID_HIGH: assert property (
    rd_id |-> wb_dat_o[31:8] == '0 && wb_dat_o[5:4] == 2'h0
      && wb_dat_o[7] == wb_dat_o[6]
  ) else $error("identification high bits wrong");
  AST_TEMT: assert property (
    rd_ls && wb_dat_o[6] |-> wb_dat_o[5]
  ) else $error("transmitter empty without holding empty");
  AST_TX_HOLD: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o)
  ) else $error("transmit character not held");
endmodule : ufc_top_checker
bind ufc_top ufc_top_checker ufc_top_checker_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
  .tx_ready_i(tx_ready_i)
);
`default_nettype wire

// file: test/ufc_link_model.sv
/*
  Serial shifter stand-in: baud ticks, transmit take-up and busy.
  Assumes the block's clock and synchronous active-high reset.
*/
`default_nettype none
module ufc_link_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  input  wire logic tx_valid_i,
  output logic      baud_tick_o,
  output logic      tx_ready_o,
  output logic      tx_busy_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] busy_cnt;
  always_ff @(posedge clk_i) begin
    baud_tick_o <= rst_i ? 1'h0 : !baud_tick_o;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i)
      busy_cnt <= '0;
    else if (tx_valid_i && tx_ready_o)
      busy_cnt <= slow_i ? 9'h140 : 9'h014;
    else if (busy_cnt != '0)
      busy_cnt <= busy_cnt - 9'h001;
  end
  assign tx_ready_o = busy_cnt == '0;
  assign tx_busy_o = busy_cnt != '0;
endmodule : ufc_link_model
`default_nettype wire

// file: test/test_uart_fifo_interrupt_control.sv
/*
  Self-checking bench for the FIFO and interrupt control block.
  Assumes ufc_pkg, ufc_top, ufc_link_model and the bound checker.
*/
`default_nettype none
module test_uart_fifo_interrupt_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'h0, rst_i = 1'h1, slow = 1'h0, rx_valid_i = 1'h0;
  logic wb_we_i = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic [4:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, q;
  logic [3:0] wb_sel_i = '0;
  logic [7:0] rx_data_i = '0, tx_data_o;
  logic [2:0] rx_err_i = '0;
  logic wb_ack_o, baud_tick_i, tx_valid_o, tx_ready_i, tx_busy_i, irq_o;
  int miscompares = 0, checks = 0;
  logic [31:0] lfsr = 32'h7175da3f;
  logic [7:0] rxq[$], txq[$];
  logic [4:0] lv[4] = '{ufc_pkg::TRIG_00, ufc_pkg::TRIG_01,
                        ufc_pkg::TRIG_10, ufc_pkg::TRIG_11};
  ufc_top ufc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .baud_tick_i(baud_tick_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .rx_err_i(rx_err_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .tx_busy_i(tx_busy_i),
    .irq_o(irq_o));
  ufc_link_model ufc_link_model_inst (.clk_i(clk_i), .rst_i(rst_i),
    .slow_i(slow), .tx_valid_i(tx_valid_o), .baud_tick_o(baud_tick_i),
    .tx_ready_o(tx_ready_i), .tx_busy_o(tx_busy_i));
  initial begin
    forever #12.5 clk_i = !clk_i;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    q = wb_dat_o;
    if (n >= 50)
      cmp(32'h0, 32'h1);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : wb
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    wb(1'h0, a, 8'h00);
    cmp(q, {24'h0, e});
  endtask : rdc
  task automatic rid(input logic [7:0] e);
    rdc(ufc_pkg::ADR_IID, e);
  endtask : rid
  task automatic rls(input logic [7:0] e);
    rdc(ufc_pkg::ADR_LST, e);
  endtask : rls
  task automatic wfc(input logic [7:0] d);
    wb(1'h1, ufc_pkg::ADR_IID, d);
  endtask : wfc
  task automatic wie(input logic [7:0] d);
    wb(1'h1, ufc_pkg::ADR_IEN, d);
  endtask : wie
  task automatic irqc(input logic e);
    cmp({31'h0, irq_o}, {31'h0, e});
  endtask : irqc
  task automatic pop;
    wb(1'h0, ufc_pkg::ADR_DATA, 8'h00);
    cmp(q, {24'h0, rxq.pop_front()});
  endtask : pop
  task automatic txw;
    lfsr = next_rand(lfsr);
    txq.push_back(lfsr[7:0]);
    wb(1'h1, ufc_pkg::ADR_DATA, lfsr[7:0]);
  endtask : txw
  task automatic push(input logic [2:0] e);
    lfsr = next_rand(lfsr);
    @(posedge clk_i);
    rx_valid_i <= 1'h1;
    rx_data_i <= lfsr[7:0];
    rx_err_i <= e;
    rxq.push_back(lfsr[7:0]);
    @(posedge clk_i);
    rx_valid_i <= 1'h0;
    rx_data_i <= ~lfsr[7:0];
    rx_err_i <= ~e;
  endtask : push
  always @(posedge clk_i) begin
    if (!rst_i && tx_valid_o === 1'h1 && tx_ready_i === 1'h1)
      cmp({24'h0, tx_data_o}, {24'h0, txq.pop_front()});
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    rid(8'h01);
    rdc(ufc_pkg::ADR_IEN, 8'h00);
    rdc(5'h14, 8'h00);
    wfc(8'h01);
    rid(8'hc1);
    wie(8'h02);
    rid(8'hc2);
    rid(8'hc1);
    txw();
    repeat (50) @(posedge clk_i);
    rid(8'hc1);
    repeat (400) @(posedge clk_i);
    irqc(1'h1);
    rid(8'hc2);
    $display("test transmit-empty done");
    for (int t = 0; t < 4; t++) begin
      wfc({t[1:0], 6'h03});
      wie(8'h01);
      rxq.delete();
      for (int i = 1; i < lv[t]; i++)
        push(3'h0);
      rid(8'hc1);
      irqc(1'h0);
      push(3'h0);
      rid(8'hc4);
      irqc(1'h1);
      pop();
      rid(8'hc1);
      wfc({t[1:0], 6'h03});
      rxq.delete();
      rls(8'h60);
    end
    $display("test trigger levels done");
    push(3'h0);
    push(3'h0);
    repeat (1000) @(posedge clk_i);
    rid(8'hc1);
    repeat (400) @(posedge clk_i);
    rid(8'hcc);
    pop();
    rid(8'hc1);
    repeat (1000) @(posedge clk_i);
    rid(8'hc1);
    repeat (400) @(posedge clk_i);
    rid(8'hcc);
    pop();
    $display("test time-out done");
    wie(8'h07);
    push(3'h1);
    rid(8'hc6);
    rls(8'he5);
    rid(8'hc2);
    rid(8'hc1);
    pop();
    rls(8'h60);
    $display("test line status done");
    wie(8'h00);
    slow <= 1'h1;
    repeat (3) txw();
    rls(8'h00);
    wfc(8'h05);
    if (tx_valid_o === 1'h1)
      txq = txq[0:0];
    else
      txq.delete();
    rls(8'h20);
    repeat (800) @(posedge clk_i);
    rls(8'h60);
    cmp(32'(txq.size()), 32'h0);
    slow <= 1'h0;
    $display("test transmit flush done");
    wie(8'h01);
    push(3'h0);
    push(3'h0);
    wfc(8'h00);
    rxq.delete();
    rid(8'h01);
    rls(8'h60);
    push(3'h0);
    rid(8'h04);
    pop();
    $display("test fifo off done");
    complete_run();
  end
endmodule : test_uart_fifo_interrupt_control
`default_nettype wire
